// ---- pkg/spi_slave_regs.vh ----
`ifndef SPI_SLAVE_REGS_VH
`define SPI_SLAVE_REGS_VH
// serial byte and address geometry
`define BYTE_W        8
`define ADDR_W        16
`define BIT_CNT_W     3
`define BIT_LAST      3'h7
`define BIT_ZERO      3'h0
`define BIT_STEP      3'h1
`define BYTE_ZERO     8'h00
`define ADDR_ZERO     16'h0000
`define ADDR_STEP     16'h0001
// page register fields
`define PAGE_W        9
`define PAGE_RST      9'h000
`define LO1B_W        7
`define LO2B_W        15
// direction flag value for a read
`define DIR_READ      1'b1
// synchroniser depth
`define SYNC_W        3
`endif

// ---- core/pin_sync.v ----
`timescale 1ns/100ps
// three-stage synchroniser; output changes once stages one and two agree
// reset level should match the idle level of the pin, so no false edge follows reset
module pin_sync #(
  parameter RST_VAL = 1'b0
) (
  // clock and reset
  input  wire clk,
  input  wire srst,
  // raw pin and filtered level
  input  wire pin_in,
  output reg  level_r
);
  reg [2:0] sync_r;

  // stage 0 is read only by stage 1
  always @(posedge clk) begin
    if (srst) begin
      sync_r  <= {3{RST_VAL}};
      level_r <= RST_VAL;
    end else begin
      sync_r <= {sync_r[1:0], pin_in};
      if (sync_r[1] == sync_r[2])
        level_r <= sync_r[2];
    end
  end
endmodule // pin_sync

// ---- core/spi_slave_paged.v ----
`timescale 1ns/100ps
`include "spi_slave_regs.vh"
// Overview of operation
// - first bit of each access: zero means write, one means read
// - 2-byte mode: two command bytes hold flag and fifteen address bits
// - optional read data launch half an sclk earlier, on the edge opposite the sample edge
// - data line released to high impedance when chip select rises
// - 1-byte address is page nine bits above seven access bits
// - 2-byte address is page top bit above fifteen access bits
// - pointer increments after each data byte within a burst
// - 4-wire mode default, 3-wire mode uses one bidirectional line
module spi_slave_paged (
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  // serial pins
  input  wire        cs_n,
  input  wire        sclk,
  input  wire        serial_data_in,
  input  wire        sdio_in,
  output reg         sdio_out_r,
  output reg         sdio_oe_r,
  // configuration
  input  wire        addr_2b,
  input  wire        three_wire,
  input  wire        sample_fall,
  input  wire        read_delay,
  // page register contents, loaded by the register space
  input  wire [8:0]  page_val,
  // register space access
  output reg  [15:0] reg_addr_r,
  output reg  [7:0]  wr_data_r,
  output reg         wr_stb_r,
  output reg         rd_stb_r,
  input  wire [7:0]  rd_data,
  output reg         busy_r
);
  localparam ST_CMD0 = 2'h0;
  localparam ST_CMD1 = 2'h1;
  localparam ST_DATA = 2'h2;

  wire cs_n_s;
  wire sclk_s;
  wire din_s;
  wire dio_s;
  reg  sclk_d_r;
  reg  [1:0] state_r;
  reg  [2:0] bit_r;
  reg  [7:0] shift_r;
  reg  [7:0] cmd0_r;
  reg  [7:0] tx_r;
  reg        rd_r;
  reg        launch_r;

  // chip select and link clock idle high; their stages start high so that
  // reset release shows neither a select nor a clock edge
  pin_sync #(.RST_VAL(1'b1)) u_cs (.clk(clk), .srst(srst), .pin_in(cs_n), .level_r(cs_n_s));
  pin_sync #(.RST_VAL(1'b1)) u_ck (.clk(clk), .srst(srst), .pin_in(sclk), .level_r(sclk_s));
  // data pins need no special level: they are only read inside a frame
  pin_sync u_di (.clk(clk), .srst(srst), .pin_in(serial_data_in), .level_r(din_s));
  pin_sync u_do (.clk(clk), .srst(srst), .pin_in(sdio_in), .level_r(dio_s));

  // edge finding on the filtered clock level
  wire rise  = sclk_s & ~sclk_d_r;
  wire fall  = ~sclk_s & sclk_d_r;
  wire samp  = sample_fall ? fall : rise;
  wire oppo  = sample_fall ? rise : fall;
  wire sdata = three_wire ? dio_s : din_s;
  wire [7:0] byte_in = {shift_r[6:0], sdata};

  // launch edge: same as sample edge, or the opposite edge half a period earlier when delayed
  wire launch = read_delay ? oppo : samp;

  // address forming from page bits and access bits
  function [15:0] form_addr;
    input       two_b;
    input [8:0] pg;
    input [14:0] lo;
    begin
      if (two_b)
        form_addr = {pg[8], lo};
      else
        form_addr = {pg, lo[6:0]};
    end
  endfunction

  // serial engine; all framing ends when chip select rises
  // limitation: every pin passes the synchroniser, so the block reacts to a
  // link edge some four to five clocks late; read data therefore reaches the
  // host one link period after its launch edge, and the link clock must be
  // at least eight system clocks long
  always @(posedge clk) begin
    if (srst) begin
      sclk_d_r   <= 1'b1;                         // idle high, as the synchroniser
      state_r    <= ST_CMD0;
      bit_r      <= `BIT_ZERO;
      shift_r    <= `BYTE_ZERO;
      cmd0_r     <= `BYTE_ZERO;
      tx_r       <= `BYTE_ZERO;
      rd_r       <= 1'b0;
      launch_r   <= 1'b0;
      reg_addr_r <= `ADDR_ZERO;
      wr_data_r  <= `BYTE_ZERO;
      wr_stb_r   <= 1'b0;
      rd_stb_r   <= 1'b0;
      busy_r     <= 1'b0;
      sdio_out_r <= 1'b0;
      sdio_oe_r  <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      busy_r   <= ~cs_n_s;
      if (cs_n_s) begin
        state_r   <= ST_CMD0;
        bit_r     <= `BIT_ZERO;
        rd_r      <= 1'b0;
        launch_r  <= 1'b0;
        sdio_oe_r <= 1'b0;
      end else begin
        // fetched read byte lands one cycle after its strobe
        if (rd_stb_r)
          tx_r <= rd_data;
        // write pointer steps after its strobe, so the strobe sees a steady address
        if (wr_stb_r)
          reg_addr_r <= reg_addr_r + `ADDR_STEP;
        if (samp) begin
          shift_r <= byte_in;
          bit_r   <= bit_r + `BIT_STEP;
          if (bit_r == `BIT_LAST) begin
            case (state_r)
              ST_CMD0: begin
                cmd0_r <= byte_in;
                rd_r   <= (byte_in[7] == `DIR_READ);
                if (addr_2b) begin
                  state_r <= ST_CMD1;
                end else begin
                  state_r    <= ST_DATA;
                  reg_addr_r <= form_addr(1'b0, page_val, {8'h00, byte_in[6:0]});
                  rd_stb_r   <= (byte_in[7] == `DIR_READ);
                end
              end
              ST_CMD1: begin
                state_r    <= ST_DATA;
                reg_addr_r <= form_addr(1'b1, page_val, {cmd0_r[6:0], byte_in});
                rd_stb_r   <= rd_r;
              end
              ST_DATA: begin
                if (!rd_r) begin
                  // write lands at the current pointer; it moves a cycle later
                  wr_data_r <= byte_in;
                  wr_stb_r  <= 1'b1;
                end else begin
                  // read pointer moves now, so the prefetch fetches the next byte
                  reg_addr_r <= reg_addr_r + `ADDR_STEP;
                  rd_stb_r   <= 1'b1;
                end
              end
              default: state_r <= ST_CMD0;
            endcase
          end
        end
        // read output: first launch after the address puts out the msb
        if (state_r == ST_DATA && rd_r && launch) begin
          if (!launch_r) begin
            launch_r   <= 1'b1;
            sdio_oe_r  <= 1'b1;
            sdio_out_r <= tx_r[7];
            tx_r       <= {tx_r[6:0], 1'b0};
          end else begin
            sdio_out_r <= tx_r[7];
            tx_r       <= {tx_r[6:0], 1'b0};
          end
        end
        // next byte is reloaded at its strobe; msb launches on the next edge
      end
    end
  end
endmodule // spi_slave_paged

// ---- dv/spi_slave_paged_asserts.sv ----
`timescale 1ns/100ps
module spi_slave_paged_chk (
  // clock and reset
  input wire        clk,
  input wire        srst,
  // pins and config
  input wire        cs_n,
  input wire        sdio_oe_r,
  input wire        addr_2b,
  input wire [8:0]  page_val,
  // register side
  input wire [15:0] reg_addr_r,
  input wire        wr_stb_r,
  input wire        rd_stb_r,
  input wire        busy_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // deselect long enough to pass the pin synchroniser
  sequence s_idle; cs_n [*8]; endsequence
  sequence s_acc; wr_stb_r || rd_stb_r; endsequence
  property p_oe; s_idle |-> !sdio_oe_r; endproperty
  a_oe: assert property (p_oe) else $error("line driven while idle");
  property p_idle; s_idle |-> !busy_r; endproperty
  a_idle: assert property (p_idle) else $error("busy while idle");
  property p_wr; wr_stb_r |-> busy_r ##1 !wr_stb_r; endproperty
  a_wr: assert property (p_wr) else $error("bad write pulse");
  property p_rd; rd_stb_r |-> busy_r ##1 !rd_stb_r; endproperty
  a_rd: assert property (p_rd) else $error("bad read pulse");
  property p_a1; s_acc |-> addr_2b || reg_addr_r[15:7] == page_val; endproperty
  a_a1: assert property (p_a1) else $error("page bits lost");
  property p_a2; s_acc |-> !addr_2b || reg_addr_r[15] == page_val[8]; endproperty
  a_a2: assert property (p_a2) else $error("top bit lost");
  property p_inc; wr_stb_r ##1 !wr_stb_r [*8] |-> $stable(reg_addr_r); endproperty
  a_inc: assert property (p_inc) else $error("pointer moved early");
  property p_st; $rose(busy_r) |-> !wr_stb_r [*8]; endproperty
  a_st: assert property (p_st) else $error("write before command");
endmodule // spi_slave_paged_chk
bind spi_slave_paged spi_slave_paged_chk u_chk (.clk, .srst, .cs_n, .sdio_oe_r, .addr_2b,
  .page_val, .reg_addr_r, .wr_stb_r, .rd_stb_r, .busy_r);

// ---- dv/spi_host.sv ----
`timescale 1ns/100ps
// host model; sclk idles high and only moves inside a frame
module spi_host (
  input  wire clk,
  input  wire miso,
  output reg  cs_n,
  output reg  sclk,
  output reg  mosi
);
  integer i;
  initial {cs_n, sclk, mosi} = 3'h6;
  // one frame of nb bytes; 320 ns sclk is eight clocks, exactly the shortest link period the port allows
  // read bits are taken early in the following slot, past the device's sync latency
  task xfer(input [39:0] tx, input integer nb, output [39:0] rx);
    @(posedge clk) cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (i = nb * 8 - 1; i >= 0; i = i - 1) begin
      mosi <= tx[i];
      sclk <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      if (i < nb * 8 - 1)
        rx[i + 1] = miso;
      @(posedge clk);
      @(posedge clk) sclk <= 1'b1;
      repeat (4) @(posedge clk);
    end
    repeat (2) @(posedge clk);
    @(negedge clk) rx[0] = miso;
    @(posedge clk) cs_n <= 1'b1;
    mosi <= ~mosi; // stale level must not look valid
    repeat (8) @(posedge clk);
  endtask
endmodule // spi_host

// ---- dv/tb.sv ----
`timescale 1ns/100ps
module tb;
  reg         clk = 1'b0;
  reg         srst = 1'b1;
  reg         addr_2b = 1'b0;
  reg  [1:0]  mode = 2'h0;
  reg  [7:0]  mem [0:255];
  reg  [39:0] rx;
  reg  [8:0]  page = 9'h000;
  reg  [8:0]  page_nxt = 9'h000;
  reg  [7:0]  pg_lo = 8'h00;
  reg  [15:0] wa;
  reg  [7:0]  wd;
  integer     n_fail = 0;
  integer     tests_run = 0;
  integer     m;
  wire        cs_n, sclk, mosi, sd_o, sd_oe, wr_s, rd_s, busy;
  wire [15:0] ra;
  wire [7:0]  wdat;
  // shared line: the device wins while its enable is up
  wire        sdio = sd_oe ? sd_o : mosi;
  initial forever #20 clk = ~clk;
  spi_host host (.clk(clk), .miso(sdio), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
  spi_slave_paged dut (.clk(clk), .srst(srst), .cs_n(cs_n), .sclk(sclk),
    .serial_data_in(mosi), .sdio_in(sdio), .sdio_out_r(sd_o), .sdio_oe_r(sd_oe),
    .addr_2b(addr_2b), .three_wire(mode[1]), .sample_fall(1'b0), .read_delay(mode[0]),
    .page_val(page), .reg_addr_r(ra), .wr_data_r(wdat), .wr_stb_r(wr_s),
    .rd_stb_r(rd_s), .rd_data(mem[ra[7:0]]), .busy_r(busy));
  // register space stand-in; page writes are staged and take effect between frames
  always @(posedge clk) if (wr_s) begin
    mem[ra[7:0]] <= wdat;
    wa <= ra;
    wd <= wdat;
    if (!addr_2b && ra[6:0] == 7'h7c) pg_lo <= wdat;
    if (!addr_2b && ra[6:0] == 7'h7d) page_nxt <= {wdat, pg_lo[7]};
    if (addr_2b && ra[14:0] == 15'h7ffd) page_nxt[8] <= wdat[7];
  end
  always @(posedge clk) if (cs_n) page <= page_nxt;
  task chk(input string nm, input [23:0] got, input [23:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000 n_fail = n_fail + 1;
    summarize;
  end
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (8) @(posedge clk);
    host.xfer(40'h7c80cb1020, 5, rx);
    host.xfer(40'h64505152, 4, rx);
    chk("waddr", wa, 16'hcbe6);
    chk("wdata", wd, 8'h52);
    for (m = 0; m < 4; m = m + 1) begin
      @(posedge clk) mode <= m[1:0];
      host.xfer(40'he4000000, 4, rx);
      chk("rd1b", rx[23:0], 24'h505152);
      chk("oe", sd_oe, 1'b0);
      chk("busy", busy, 1'b0);
    end
    host.xfer(40'h7c00001020, 5, rx);
    @(posedge clk) addr_2b <= 1'b1;
    host.xfer(40'h7ffd801020, 5, rx);
    host.xfer(40'h4be4a55a, 4, rx);
    chk("waddr2", wa, 16'hcbe5);
    host.xfer(40'hcbe40000, 4, rx);
    chk("rd2b", rx[15:0], 16'ha55a);
    summarize;
  end
endmodule // tb
